//--- rtl/lpd_pkg.sv
// Shared constants, states and carriers for the LED PWM driver
package lpd_pkg;

    // Channel count and data widths
    localparam int           LPD_CHANNELS       = 18;
    localparam int           LPD_GROUP_W        = 6;     // Enable bits per enable register
    localparam int           LPD_GRP_A_LSB      = 0;     // enable_bits_group_a position
    localparam int           LPD_GRP_B_LSB      = 6;     // enable_bits_group_b position
    localparam int           LPD_GRP_C_LSB      = 12;    // enable_bits_group_c position
    localparam int           LPD_SOFT_BIT_POS   = 0;     // soft_power_down_bit position

    // Bus address byte, write direction included
    localparam logic [7:0]   LPD_BUS_ADDR       = 8'ha8;
    localparam logic [3:0]   LPD_BYTE_BITS      = 4'h8;

    // Register offsets
    localparam logic [7:0]   LPD_REG_SHUTDOWN   = 8'h00;
    localparam logic [7:0]   LPD_REG_DUTY_FIRST = 8'h01;
    localparam logic [7:0]   LPD_REG_DUTY_LAST  = 8'h12;
    localparam logic [7:0]   LPD_REG_EN_LOW     = 8'h13;
    localparam logic [7:0]   LPD_REG_EN_MID     = 8'h14;
    localparam logic [7:0]   LPD_REG_EN_HIGH    = 8'h15;
    localparam logic [7:0]   LPD_REG_APPLY      = 8'h16;
    localparam logic [7:0]   LPD_REG_SOFT_RST   = 8'h17;

    // Values after reset
    localparam logic         LPD_SHUTDOWN_RST   = 1'b0;
    localparam logic [7:0]   LPD_PTR_RST        = 8'h00;

    // Receiver states
    typedef enum logic [2:0] {
        LPD_ST_IDLE,
        LPD_ST_ADDR,
        LPD_ST_ACK_ADDR,
        LPD_ST_REG,
        LPD_ST_ACK_REG,
        LPD_ST_DATA,
        LPD_ST_ACK_DATA,
        LPD_ST_IGNORE
    } lpd_state_type;

    // Channel configuration: enables and duties travel together
    typedef struct packed {
        logic [LPD_CHANNELS-1:0]      enable;
        logic [LPD_CHANNELS-1:0][7:0] duty;
    } lpd_cfg_type;

    localparam lpd_cfg_type LPD_CFG_RST = '0;

    // Sampled pin levels travel together
    typedef struct packed {
        logic scl;
        logic sda;
        logic pd_n;
    } lpd_pins_type;

endpackage : lpd_pkg

//--- rtl/lpd_top.sv
// Write-only two-wire slave with staged 18-channel PWM LED drive
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Answer only bus address byte a8h
// - Writes only; no register readback exists
// - Data sampled while clock high; idle high
// - Data fall with clock high starts transfer
// - Address byte arrives MSB first
// - Matching address acknowledged for whole pulse
// - Register address acknowledged, loads pointer
// - Each data byte acknowledged and written
// - Data rise with clock high returns idle
// - Pointer increments during data acknowledge
// - Increment continues for every data byte
// - Register map decode 00h to 17h
// - Bit 0 of 00h: 0 shutdown
// - Duty value over 256 sets brightness
// - Enable registers 13h-15h, bits 5:0
// - Enable bit zero forces channel off
// - Duty/enable staged until 16h written
// - Write to 17h restores all defaults
// - Soft reset and power-up give blank
// - Shutdown turns outputs off, keeps registers
// - Power-down pin low forces outputs off
module lpd_top
    import lpd_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic                    scl,
    input  wire logic                    sda_in,
    output logic                         sda_out,
    output logic                         sda_oe_n,
    input  wire logic                    power_down_pin_n,
    output logic [LPD_CHANNELS-1:0]      led_channel_outputs
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    lpd_pins_type pins_meta_reg;    // First stage, read only by second
    lpd_pins_type pins_sync_reg;    // Safe levels
    lpd_pins_type pins_prev_reg;    // Previous safe levels, for edges
    lpd_pins_type pins_meta_next;
    lpd_pins_type pins_sync_next;
    lpd_pins_type pins_prev_next;

    // Next values of the synchroniser chain
    always_comb begin
        pins_meta_next = '{scl: scl, sda: sda_in, pd_n: power_down_pin_n};
        pins_sync_next = pins_meta_reg;
        pins_prev_next = pins_sync_reg;
    end

    // Idle bus and released pin are high, so reset to ones
    always_ff @(posedge clk) begin
        if (rst) begin
            pins_meta_reg <= '1;
            pins_sync_reg <= '1;
            pins_prev_reg <= '1;
        end else begin
            pins_meta_reg <= pins_meta_next;
            pins_sync_reg <= pins_sync_next;
            pins_prev_reg <= pins_prev_next;
        end
    end

    // Edge and condition detectors on the safe copies
    logic scl_rise;                 // Clock rising: sample data
    logic scl_fall;                 // Clock falling: change our drive
    logic start_det;                // Data falls while clock high
    logic stop_det;                 // Data rises while clock high

    assign scl_rise  = pins_sync_reg.scl & ~pins_prev_reg.scl;
    assign scl_fall  = ~pins_sync_reg.scl & pins_prev_reg.scl;
    assign start_det = pins_sync_reg.scl & pins_prev_reg.scl
                     & pins_prev_reg.sda & ~pins_sync_reg.sda;
    assign stop_det  = pins_sync_reg.scl & pins_prev_reg.scl
                     & ~pins_prev_reg.sda & pins_sync_reg.sda;

    ////////////////////////////////////////////////////////////////////////////
    // Serial receiver

    lpd_state_type state_reg;       // Receiver state
    lpd_state_type state_next;
    logic [3:0]    bit_cnt_reg;     // Bits taken in current byte
    logic [3:0]    bit_cnt_next;
    logic [7:0]    shift_reg;       // Incoming byte, MSB first
    logic [7:0]    shift_next;
    logic [7:0]    ptr_reg;         // Register pointer
    logic [7:0]    ptr_next;
    logic          sda_oe_n_reg;    // Low while pulling data low
    logic          sda_oe_n_next;
    logic          wr_pulse;        // One-cycle register write
    logic [7:0]    wr_addr;
    logic [7:0]    wr_data;

    // Byte assembly, acknowledge and pointer handling
    always_comb begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        ptr_next      = ptr_reg;
        wr_pulse      = 1'b0;
        wr_addr       = ptr_reg;
        wr_data       = shift_reg;
        if (start_det) begin
            // Start or repeated start always wins
            state_next   = LPD_ST_ADDR;
            bit_cnt_next = 4'h0;
        end else if (stop_det) begin
            state_next   = LPD_ST_IDLE;
        end else begin
            case (state_reg)
                LPD_ST_ADDR, LPD_ST_REG, LPD_ST_DATA: begin
                    if (scl_rise && bit_cnt_reg != LPD_BYTE_BITS) begin
                        // Sample in the high phase, MSB first
                        shift_next   = {shift_reg[6:0], pins_sync_reg.sda};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == LPD_BYTE_BITS) begin
                        bit_cnt_next = 4'h0;
                        if (state_reg == LPD_ST_ADDR) begin
                            // Reads carry a8h|1 and so never match
                            state_next = (shift_reg == LPD_BUS_ADDR) ?
                                         LPD_ST_ACK_ADDR : LPD_ST_IGNORE;
                        end else if (state_reg == LPD_ST_REG) begin
                            ptr_next   = shift_reg;
                            state_next = LPD_ST_ACK_REG;
                        end else begin
                            wr_pulse   = 1'b1;
                            state_next = LPD_ST_ACK_DATA;
                        end
                    end
                end
                LPD_ST_ACK_ADDR: begin
                    if (scl_fall) begin
                        state_next = LPD_ST_REG;
                    end
                end
                LPD_ST_ACK_REG: begin
                    if (scl_fall) begin
                        state_next = LPD_ST_DATA;
                    end
                end
                LPD_ST_ACK_DATA: begin
                    if (scl_fall) begin
                        // Wraps at ffh; no limit on burst length
                        ptr_next   = ptr_reg + 8'h01;
                        state_next = LPD_ST_DATA;
                    end
                end
                LPD_ST_IDLE, LPD_ST_IGNORE: begin     // Only a start, or a stop from ignore, leaves these
                    state_next = state_reg;
                end
                default: begin
                    state_next = LPD_ST_IDLE;
                end
            endcase
        end
        // Pull data low for the whole acknowledge pulse
        sda_oe_n_next = !(state_next == LPD_ST_ACK_ADDR ||
                          state_next == LPD_ST_ACK_REG  ||
                          state_next == LPD_ST_ACK_DATA);
    end

    // Receiver registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg    <= LPD_ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            ptr_reg      <= LPD_PTR_RST;
            sda_oe_n_reg <= 1'b1;
        end else begin
            state_reg    <= state_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            ptr_reg      <= ptr_next;
            sda_oe_n_reg <= sda_oe_n_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file: staged and active copies

    logic        soft_power_down_bit_reg;    // 0 = software shutdown
    logic        soft_power_down_bit_next;
    lpd_cfg_type staged_reg;                 // Holding copies
    lpd_cfg_type staged_next;
    lpd_cfg_type active_reg;                 // Values driving the channels
    lpd_cfg_type active_next;
    logic [4:0]  duty_idx;                   // Channel addressed by a duty write
    logic        apply_hit;                  // Write to 16h
    logic        soft_rst_hit;               // Write to 17h

    assign duty_idx     = 5'(wr_addr - LPD_REG_DUTY_FIRST);
    assign apply_hit    = wr_pulse && wr_addr == LPD_REG_APPLY;
    assign soft_rst_hit = wr_pulse && wr_addr == LPD_REG_SOFT_RST;

    // Write decode; nothing here is ever read back
    always_comb begin
        soft_power_down_bit_next = soft_power_down_bit_reg;
        staged_next              = staged_reg;
        active_next              = active_reg;
        if (soft_rst_hit) begin
            // Any byte value resets, not only zero
            soft_power_down_bit_next = LPD_SHUTDOWN_RST;
            staged_next              = LPD_CFG_RST;
            active_next              = LPD_CFG_RST;
        end else if (apply_hit) begin
            active_next = staged_reg;
        end else if (wr_pulse) begin
            if (wr_addr == LPD_REG_SHUTDOWN) begin
                // Reserved bits 7:1 are not stored
                soft_power_down_bit_next = wr_data[LPD_SOFT_BIT_POS];
            end else if (wr_addr >= LPD_REG_DUTY_FIRST && wr_addr <= LPD_REG_DUTY_LAST) begin
                staged_next.duty[duty_idx] = wr_data;
            end else if (wr_addr == LPD_REG_EN_LOW) begin
                staged_next.enable[LPD_GRP_A_LSB +: LPD_GROUP_W] =
                    wr_data[LPD_GROUP_W-1:0];
            end else if (wr_addr == LPD_REG_EN_MID) begin
                staged_next.enable[LPD_GRP_B_LSB +: LPD_GROUP_W] =
                    wr_data[LPD_GROUP_W-1:0];
            end else if (wr_addr == LPD_REG_EN_HIGH) begin
                staged_next.enable[LPD_GRP_C_LSB +: LPD_GROUP_W] =
                    wr_data[LPD_GROUP_W-1:0];
            end else begin
                staged_next = staged_reg;    // Above 17h: acknowledged, dropped
            end
        end
    end

    // Register file storage; power-up gives a blank display
    always_ff @(posedge clk) begin
        if (rst) begin
            soft_power_down_bit_reg <= LPD_SHUTDOWN_RST;
            staged_reg              <= LPD_CFG_RST;
            active_reg              <= LPD_CFG_RST;
        end else begin
            soft_power_down_bit_reg <= soft_power_down_bit_next;
            staged_reg              <= staged_next;
            active_reg              <= active_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modulation and output stage

    logic [7:0]              pwm_cnt_reg;    // Shared free-running counter
    logic [7:0]              pwm_cnt_next;
    logic [LPD_CHANNELS-1:0] led_reg;
    logic [LPD_CHANNELS-1:0] led_next;
    logic                    run_ok;         // Neither shutdown is active
    logic                    sda_out_reg;    // Open drain: only ever drives low

    // Shutdowns gate the outputs but never touch the registers
    assign run_ok = soft_power_down_bit_reg & pins_sync_reg.pd_n;

    // Counter runs at full clock; 256 steps per period
    always_comb begin
        pwm_cnt_next = pwm_cnt_reg + 8'h01;
    end

    // One comparator per channel; duty 0 is always off
    generate
        for (genvar ch = 0; ch < LPD_CHANNELS; ch++) begin : g_chan
            always_comb begin
                led_next[ch] = run_ok && active_reg.enable[ch] &&
                               (pwm_cnt_reg < active_reg.duty[ch]);
            end
        end
    endgenerate

    // Output flops
    always_ff @(posedge clk) begin
        if (rst) begin
            pwm_cnt_reg <= 8'h00;
            led_reg     <= '0;
            sda_out_reg <= 1'b0;
        end else begin
            pwm_cnt_reg <= pwm_cnt_next;
            led_reg     <= led_next;
            sda_out_reg <= 1'b0;
        end
    end

    assign led_channel_outputs = led_reg;
    assign sda_out             = sda_out_reg;
    assign sda_oe_n            = sda_oe_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    chk_start_addr: assert property (
        start_det |=> state_reg == LPD_ST_ADDR && bit_cnt_reg == 4'h0)
        else $error("start did not begin address phase");
    chk_stop_idle: assert property (stop_det |=> state_reg == LPD_ST_IDLE)
        else $error("stop did not return to idle");
    chk_addr_match: assert property (
        state_reg == LPD_ST_ADDR && scl_fall && !start_det && !stop_det
        && bit_cnt_reg == LPD_BYTE_BITS |=>
        (!sda_oe_n) == ($past(shift_reg) == LPD_BUS_ADDR))
        else $error("acknowledge does not follow address match");
    chk_ack_hold: assert property (
        $rose(sda_oe_n) |-> $past(scl_fall || start_det || stop_det))
        else $error("acknowledge released before clock fall");
    chk_ignore_quiet: assert property (state_reg == LPD_ST_IGNORE |-> sda_oe_n)
        else $error("drive while ignoring transfer");
    chk_ptr_inc: assert property (
        state_reg == LPD_ST_ACK_DATA && scl_fall && !start_det && !stop_det
        |=> ptr_reg == $past(ptr_reg) + 8'h01)
        else $error("pointer did not advance");
    chk_apply_copy: assert property (apply_hit |=> active_reg == $past(staged_reg))
        else $error("apply did not copy staged values");
    chk_active_hold: assert property (
        !apply_hit && !soft_rst_hit |=> $stable(active_reg))
        else $error("active values changed without apply");
    chk_soft_reset: assert property (
        soft_rst_hit |=> staged_reg == LPD_CFG_RST && active_reg == LPD_CFG_RST
        && !soft_power_down_bit_reg)
        else $error("soft reset left a value");
    chk_shutdown_off: assert property (!run_ok |=> led_channel_outputs == '0)
        else $error("output on during shutdown");
    chk_enable_off: assert property (
        !active_reg.enable[0] |=> !led_channel_outputs[0])
        else $error("disabled channel is on");
    chk_pwm_cmp: assert property (
        ##1 led_channel_outputs[5] == $past(run_ok && active_reg.enable[5]
        && pwm_cnt_reg < active_reg.duty[5]))
        else $error("channel output does not match compare");
endmodule : lpd_top

//--- tb/lpd_master_model.sv
// Bus master model that writes frames to the LED driver
`timescale 1ns/1ps
module lpd_master_model
    import lpd_pkg::*;
(
    input  wire logic clk,
    input  wire logic sda_wire,
    output logic      scl,
    output logic      sda_drv
);
    // Clocks per quarter bit. The default gives 100 ns bits, far above the
    // 400kHz limit, only to keep the run short; the bench sets 130 for a
    // frame at the real limit
    localparam int Q_FAST  = 5;
    int            quarter = Q_FAST;

    ////////////////////////////////////////
    // Both lines released while idle
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // Wait a number of system clocks
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    // One bit; data moves only while the clock is low
    task automatic put_bit(input logic b);
        scl <= 1'b0;
        tick(quarter);
        sda_drv <= b;
        tick(quarter);
        scl <= 1'b1;
        tick(2 * quarter);
    endtask : put_bit

    ////////////////////////////////////////
    // Whole frame, MSB first; gives up at once when not acknowledged
    task automatic write_frame(input logic [23:0][7:0] bytes, input int n,
                               output logic [23:0] nack);
        nack = '0;
        tick(quarter);
        sda_drv <= 1'b0; // Start: data falls, clock high
        tick(2 * quarter);
        for (int k = 0; k < n; k++) begin
            for (int b = 7; b >= 0; b--) begin
                put_bit(bytes[k][b]);
            end
            put_bit(1'b1); // Released so the slave can answer
            nack[k] = sda_wire;
            if (nack[k] !== 1'b0) begin
                break; // No answer: straight to stop
            end
        end
        scl <= 1'b0;
        tick(quarter);
        sda_drv <= 1'b0;
        tick(quarter);
        scl <= 1'b1;
        tick(2 * quarter);
        sda_drv <= 1'b1;   // Stop: data rises, clock high
        tick(4 * quarter); // Bus free time before any next start
    endtask : write_frame
endmodule : lpd_master_model

//--- tb/lpd_top_tb_top.sv
// Self-checking bench for the LED driver
`timescale 1ns/1ps
module lpd_top_tb_top
    import lpd_pkg::*;
;
    logic                    clk              = 1'b0;
    logic                    rst              = 1'b1;
    logic                    power_down_pin_n = 1'b1;
    logic                    scl;
    logic                    sda_drv;     // Master side, 1 = released
    logic                    sda_out;
    logic                    sda_oe_n;
    logic                    sda_wire;    // Resolved open-drain level
    logic [LPD_CHANNELS-1:0] led;
    logic [17:0][7:0]        duty_t;      // Duty chosen per channel
    int                      bad_count = 0;
    int                      checked   = 0;

    // 200 MHz system clock
    always #2.5 clk = ~clk;
    // Pull-up wins unless someone pulls low
    assign sda_wire = (sda_oe_n | sda_out) & sda_drv;

    lpd_top u_dut (.clk(clk), .rst(rst), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .power_down_pin_n(power_down_pin_n), .led_channel_outputs(led));
    lpd_master_model u_master (.clk(clk), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv));

    ////////////////////////////////////////
    // Compare and count
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    // One frame; bytes in dat listed first-sent on the left
    task automatic wr(input logic [7:0] adr, input logic [7:0] ptr,
                      input logic [21:0][7:0] dat, input int n);
        logic [23:0][7:0] f;
        logic [23:0]      nack;
        f    = '0;
        f[0] = adr;
        f[1] = ptr;
        for (int k = 0; k < n; k++) begin
            f[k + 2] = dat[n - 1 - k];
        end
        u_master.write_frame(f, n + 2, nack);
        check("ack", nack, (adr === LPD_BUS_ADDR) ? 32'h0 : 32'h1);
    endtask : wr

    // Count on-cycles over one full 256-clock period per channel
    task automatic levels(input string what, input logic [17:0] en, input logic run);
        int cnt [18];
        cnt = '{default: 0};
        repeat (8) @(posedge clk);
        for (int t = 0; t < 256; t++) begin
            @(posedge clk);
            #1;
            for (int i = 0; i < 18; i++) begin
                if (led[i] === 1'b1) begin
                    cnt[i]++;
                end
            end
        end
        for (int i = 0; i < 18; i++) begin
            check(what, cnt[i], (run && en[i]) ? {24'h0, duty_t[i]} : 32'h0);
        end
    endtask : levels

    ////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        check("led reset", led, 18'h0);
        check("oe reset", sda_oe_n, 1'b1);
        check("out low", sda_out, 1'b0);
        $display("test reset done");
    endtask : t_reset

    // Auto-increment across duties and enables; held until applied
    task automatic t_stage();
        logic [21:0][7:0] d;
        d = '0;
        for (int k = 0; k < 18; k++) begin
            d[20 - k] = duty_t[k];
        end
        d[2:0] = {8'h3f, 8'h3f, 8'h3f};
        wr(LPD_BUS_ADDR, 8'h01, d, 21);
        wr(LPD_BUS_ADDR, 8'h00, 8'h01, 1);
        levels("staged", 18'h0, 1'b0);
        wr(LPD_BUS_ADDR, 8'h16, 8'h00, 1);
        levels("applied", 18'h3ffff, 1'b1);
        $display("test stage done");
    endtask : t_stage

    // Enable groups, reserved bits ignored, apply reached by increment
    task automatic t_enable();
        wr(LPD_BUS_ADDR, 8'h13, {8'h3f, 8'h00, 8'he0, 8'h00}, 4);
        levels("groups", 18'h2003f, 1'b1);
        wr(LPD_BUS_ADDR, 8'h14, {8'h3f, 8'h3f, 8'h00}, 3);
        levels("regroup", 18'h3ffff, 1'b1);
        $display("test enable done");
    endtask : t_enable

    // Soft and pin shutdown keep register contents
    task automatic t_shutdown();
        wr(LPD_BUS_ADDR, 8'h00, 8'h00, 1);
        levels("soft off", 18'h3ffff, 1'b0);
        wr(LPD_BUS_ADDR, 8'h00, 8'h01, 1);
        levels("soft on", 18'h3ffff, 1'b1);
        @(posedge clk);
        power_down_pin_n <= 1'b0;
        levels("pin off", 18'h3ffff, 1'b0);
        @(posedge clk);
        power_down_pin_n <= 1'b1;
        levels("pin on", 18'h3ffff, 1'b1);
        $display("test shutdown done");
    endtask : t_shutdown

    // Foreign and read addresses get no answer and change nothing
    task automatic t_address();
        logic [2:0][7:0] other;
        other = {8'ha9, 8'h28, 8'ha0};
        for (int i = 0; i < 3; i++) begin
            wr(other[i], 8'h00, 8'h00, 1);
        end
        levels("foreign", 18'h3ffff, 1'b1);
        $display("test address done");
    endtask : t_address

    // Writes past the map are answered and dropped
    task automatic t_above();
        wr(LPD_BUS_ADDR, 8'h18, {8'h00, 8'h00, 8'h00}, 3);
        levels("unmapped", 18'h3ffff, 1'b1);
        $display("test above done");
    endtask : t_above

    // Soft reset clears shutdown, duties and enables
    task automatic t_soft();
        wr(LPD_BUS_ADDR, 8'h17, 8'h00, 1);
        levels("reset off", 18'h3ffff, 1'b0);
        // One frame at 2.6 us bits, inside the real bus limit
        u_master.quarter = 130;
        wr(LPD_BUS_ADDR, 8'h00, 8'h01, 1);
        u_master.quarter = 5;
        wr(LPD_BUS_ADDR, 8'h16, 8'h00, 1);
        levels("defaults", 18'h0, 1'b1);
        $display("test soft done");
    endtask : t_soft

    ////////////////////////////////////////
    // Verdict and end of run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Tests need about 30000 clocks; cut off well beyond that
    initial begin
        repeat (80000) @(posedge clk);
        bad_count++;
        $display("CHECK FAILED watchdog expected done seen hang");
        give_verdict();
    end

    // Main sequence
    initial begin
        for (int k = 0; k < 18; k++) begin
            duty_t[k] = (k == 17) ? 8'hff : 8'(13 * k);
        end
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        t_reset();
        t_stage();
        t_enable();
        t_shutdown();
        t_address();
        t_above();
        t_soft();
        give_verdict();
    end
endmodule : lpd_top_tb_top
